// file: pkg/tlrc_pkg.sv
// constants, field widths and enumerations of the three-loop clock router
// assumes one core clock of 100 MHz; the analog loops are modelled as tick streams
package tlrc_pkg;
  localparam int NUM_LOOPS = 3;
  localparam int NUM_OUTS = 3;
  localparam int PRE_W = 8;
  localparam int FB_W = 11;
  localparam int PD_W = 7;
  localparam int CAP_W = 6;
  localparam int DRV_W = 2;
  localparam int CREDIT_W = 16;
  localparam logic [CREDIT_W-1:0] CREDIT_LIMIT = 16'h8000;
  localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
  localparam logic [PD_W-1:0] PD_ZERO = 7'h00;
  localparam logic [PD_W-1:0] PD_ONE = 7'h01;
  localparam logic [CAP_W-1:0] CAP_OFF = 6'h00;
  // load capacitance per code step and its range, in pF
  localparam real CAP_STEP_PF = 0.375;
  localparam real CAP_MIN_PF = 6.0;
  localparam real CAP_MAX_PF = 30.0;
  localparam real BYPASS_MAX_MHZ = 166.0;
  // core clock frequency in MHz, and loop lock time after power-up or wake, in ms
  localparam real CORE_CLK_MHZ = 100.0;
  localparam real LOCK_TIME_TYP_MS = 1.0;
  localparam real LOCK_TIME_MAX_MS = 3.0;
  localparam int LOCK_CYCLES_TYP = int'($floor(LOCK_TIME_TYP_MS * 1000.0 * CORE_CLK_MHZ));
  localparam int LOCK_CYCLES_MAX = int'($floor(LOCK_TIME_MAX_MS * 1000.0 * CORE_CLK_MHZ));

  typedef enum logic [1:0] {
    MFI_FREQ_SEL,
    MFI_SUSPEND,
    MFI_OUT_ENABLE,
    MFI_SHUTDOWN
  } tlrc_mfi_e;

  typedef enum logic [1:0] {
    SRC_REF,
    SRC_LOOP_ONE,
    SRC_LOOP_TWO,
    SRC_LOOP_THREE
  } tlrc_src_e;
endpackage : tlrc_pkg

// file: rtl/tlrc_post_div.sv
// post divider: one output toggle per div_value source ticks (ticks are half periods)
// assumes tick is a one-cycle pulse on the core clock
module tlrc_post_div
  import tlrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic tick,
  input wire logic [PD_W-1:0] div_value,
  output logic q
);
  logic [PD_W-1:0] count;
  logic [PD_W-1:0] active_div;
  logic [PD_W-1:0] next_div;
  wire logic [PD_W-1:0] eff_div = (div_value == PD_ZERO) ? PD_ONE : div_value;
  wire logic terminal = tick && (count >= active_div - PD_ONE);
  // new value only at the end of a whole period: no runt or short cycle
  assign next_div = (terminal && q) ? eff_div : active_div;

  always_ff @(posedge clk) begin
    if (rst || (ce && clear)) begin
      count <= PD_ZERO;
      q <= 1'b0;
      active_div <= PD_ONE;
    end else if (ce && clear == 1'b0) begin
      active_div <= (q == 1'b0 && count == PD_ZERO) ? eff_div : next_div;
      if (terminal) begin
        count <= PD_ZERO;
        q <= ~q;
      end else if (tick) begin
        count <= count + PD_ONE;
      end
    end
  end

  a_div_holds_mid: assert property (@(posedge clk) disable iff (rst)
    ce && !clear && (q || count != PD_ZERO) && !(terminal && q) |=> active_div == $past(active_div))
    else $error("post divider value changed mid period");
endmodule : tlrc_post_div

// file: rtl/tlrc_clock_ctrl.sv
// three-loop clock generator control: loops, crosspoint, post dividers, multi-function pin
// assumes ref_in and freq_select are asynchronous pins; configuration ports are static
module tlrc_clock_ctrl
  import tlrc_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYCLES_TYP
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic REF_IN,
  input wire logic FREQ_SELECT,
  input wire tlrc_mfi_e MFI_MODE,
  input wire logic SUSPEND_WITH_FS,
  input wire logic [PRE_W-1:0] LOOP_ONE_PRE_0,
  input wire logic [FB_W-1:0] LOOP_ONE_FB_0,
  input wire logic [PRE_W-1:0] LOOP_ONE_PRE_1,
  input wire logic [FB_W-1:0] LOOP_ONE_FB_1,
  input wire logic [PRE_W-1:0] LOOP_TWO_PRE,
  input wire logic [FB_W-1:0] LOOP_TWO_FB,
  input wire logic [PRE_W-1:0] LOOP_THREE_PRE,
  input wire logic [FB_W-1:0] LOOP_THREE_FB,
  input wire tlrc_src_e SRC_SEL_A,
  input wire tlrc_src_e SRC_SEL_B,
  input wire tlrc_src_e SRC_SEL_C,
  input wire logic [PD_W-1:0] DIV_A_0,
  input wire logic [PD_W-1:0] DIV_A_1,
  input wire logic [PD_W-1:0] DIV_B_0,
  input wire logic [PD_W-1:0] DIV_B_1,
  input wire logic [PD_W-1:0] DIV_C,
  input wire logic [NUM_OUTS-1:0] INVERT_PHASE,
  input wire logic [NUM_LOOPS-1:0] SUSPEND_LOOPS,
  input wire logic [NUM_OUTS-1:0] SUSPEND_OUTS,
  input wire logic [CAP_W-1:0] LOAD_CAP_CODE,
  input wire logic [DRV_W-1:0] OSC_DRIVE,
  input wire logic CAP_BYPASS,
  output logic CLK_OUT_A,
  output logic CLK_OUT_A_OE,
  output logic CLK_OUT_B,
  output logic CLK_OUT_B_OE,
  output logic CLK_OUT_C,
  output logic CLK_OUT_C_OE,
  output logic OSC_FEEDBACK_OUT,
  output logic OSC_FEEDBACK_OUT_OE,
  output logic OSC_ENABLE,
  output logic [CAP_W-1:0] LOAD_CAP_SEL,
  output logic [DRV_W-1:0] OSC_DRIVE_SEL,
  output logic [NUM_LOOPS-1:0] LOOP_LOCKED
);
  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam logic [LOCK_W-1:0] LOCK_DONE = LOCK_W'(LOCK_CYCLES);
  localparam logic [LOCK_W-1:0] LOCK_ZERO = '0;
  localparam logic [LOCK_W-1:0] LOCK_STEP = LOCK_W'(1);
  localparam int LOCK_CHK_W = $clog2(LOCK_CYCLES_MAX + 2);
  localparam logic [LOCK_CHK_W-1:0] LOCK_CHK_MAX = LOCK_CHK_W'(LOCK_CYCLES_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: the first stage feeds only the second
  logic ref_s1, ref_s2, ref_prev;
  logic fs_s1, fs_s2;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_prev <= 1'b0;
      fs_s1 <= 1'b1;
      fs_s2 <= 1'b1;
    end else if (CE) begin
      ref_s1 <= REF_IN;
      ref_s2 <= ref_s1;
      ref_prev <= ref_s2;
      fs_s1 <= FREQ_SELECT;
      fs_s2 <= fs_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multi-function pin decode
  wire logic pin_low = ~fs_s2;
  wire logic fs_mode = (MFI_MODE == MFI_FREQ_SEL);
  wire logic fs_high = fs_mode && fs_s2;
  wire logic shutdown = (MFI_MODE == MFI_SHUTDOWN) && pin_low;
  wire logic out_disable = (MFI_MODE == MFI_OUT_ENABLE) && pin_low;
  // suspend runs alone or alongside frequency select
  wire logic suspend = pin_low && ((MFI_MODE == MFI_SUSPEND) || (fs_mode && SUSPEND_WITH_FS));
  wire logic [NUM_LOOPS-1:0] loop_run = (shutdown || suspend) ?
    (shutdown ? '0 : ~SUSPEND_LOOPS) : '1;
  wire logic [NUM_OUTS-1:0] out_drive = (shutdown || out_disable) ? '0 :
    (suspend ? ~SUSPEND_OUTS : '1);
  wire logic ref_tick = (ref_s2 ^ ref_prev) && !shutdown;
  wire logic ref_rise = ref_s2 && !ref_prev && !shutdown;

  ////////////////////////////////////////////////////////////////////////////
  // loop models: credit of 2*feedback per reference period, one tick per prescaler
  logic [PRE_W-1:0] loop_pre [NUM_LOOPS];
  logic [FB_W-1:0] loop_fb [NUM_LOOPS];
  logic [NUM_LOOPS-1:0] loop_tick;
  logic [NUM_LOOPS-1:0] loop_src;

  assign loop_pre[0] = fs_high ? LOOP_ONE_PRE_1 : LOOP_ONE_PRE_0;
  assign loop_fb[0] = fs_high ? LOOP_ONE_FB_1 : LOOP_ONE_FB_0;
  assign loop_pre[1] = LOOP_TWO_PRE;
  assign loop_fb[1] = LOOP_TWO_FB;
  assign loop_pre[2] = LOOP_THREE_PRE;
  assign loop_fb[2] = LOOP_THREE_FB;

  for (genvar i = 0; i < NUM_LOOPS; i++) begin : g_loop
    logic [CREDIT_W-1:0] credit;
    logic [LOCK_W-1:0] lock_count;
    wire logic [CREDIT_W-1:0] pre_eff = CREDIT_W'((loop_pre[i] == PRE_ZERO) ? PRE_ONE : loop_pre[i]);
    wire logic [CREDIT_W-1:0] add = (ref_rise && credit < CREDIT_LIMIT) ?
      CREDIT_W'({loop_fb[i], 1'b0}) : '0;
    wire logic take = (credit >= pre_eff);
    wire logic [CREDIT_W-1:0] next_credit = credit + add - (take ? pre_eff : '0);
    wire logic [LOCK_W-1:0] next_lock = (lock_count == LOCK_DONE) ? lock_count : lock_count + LOCK_STEP;

    assign loop_tick[i] = take && loop_run[i];
    // ticks reach the crosspoint only once the loop has locked
    assign loop_src[i] = loop_tick[i] && (lock_count == LOCK_DONE);
    assign LOOP_LOCKED[i] = (lock_count == LOCK_DONE);

    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        credit <= '0;
        lock_count <= LOCK_ZERO;
      end else if (CE) begin
        credit <= loop_run[i] ? next_credit : '0;
        lock_count <= loop_run[i] ? next_lock : LOCK_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crosspoint and post dividers
  wire logic [3:0] src_tick = {loop_src, ref_tick};
  wire logic [NUM_OUTS-1:0] out_tick = {src_tick[SRC_SEL_C], src_tick[SRC_SEL_B], src_tick[SRC_SEL_A]};
  logic [PD_W-1:0] div_sel [NUM_OUTS];
  logic [NUM_OUTS-1:0] div_q;
  logic [NUM_OUTS-1:0] clk_q;
  logic [NUM_OUTS-1:0] oe_q;

  assign div_sel[0] = fs_high ? DIV_A_1 : DIV_A_0;
  assign div_sel[1] = fs_high ? DIV_B_1 : DIV_B_0;
  assign div_sel[2] = DIV_C;

  for (genvar o = 0; o < NUM_OUTS; o++) begin : g_out
    tlrc_post_div u_div (
      .clk(CORE_CLK),
      .rst(RST),
      .ce(CE),
      .clear(shutdown),
      .tick(out_tick[o]),
      .div_value(div_sel[o]),
      .q(div_q[o])
    );
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      clk_q <= '0;
      oe_q <= '0;
    end else if (CE) begin
      clk_q <= div_q ^ INVERT_PHASE;
      oe_q <= out_drive;
    end
  end

  assign CLK_OUT_A = clk_q[0];
  assign CLK_OUT_B = clk_q[1];
  assign CLK_OUT_C = clk_q[2];
  assign CLK_OUT_A_OE = oe_q[0];
  assign CLK_OUT_B_OE = oe_q[1];
  assign CLK_OUT_C_OE = oe_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // crystal oscillator controls
  logic osc_on;
  logic fb_q;
  logic [CAP_W-1:0] cap_q;
  logic [DRV_W-1:0] drv_q;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      osc_on <= 1'b0;
      fb_q <= 1'b0;
      cap_q <= CAP_OFF;
      drv_q <= '0;
    end else if (CE) begin
      osc_on <= !shutdown;
      fb_q <= ~ref_s2;
      cap_q <= CAP_BYPASS ? CAP_OFF : LOAD_CAP_CODE;
      drv_q <= OSC_DRIVE;
    end
  end

  // with a driven reference the feedback pin floats
  assign OSC_FEEDBACK_OUT = fb_q;
  assign OSC_FEEDBACK_OUT_OE = osc_on && !CAP_BYPASS;
  assign OSC_ENABLE = osc_on;
  assign LOAD_CAP_SEL = cap_q;
  assign OSC_DRIVE_SEL = drv_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [LOCK_CHK_W-1:0] wait_lock;

  always_ff @(posedge CORE_CLK) begin
    if (RST || !loop_run[0] || LOOP_LOCKED[0]) begin
      wait_lock <= '0;
    end else if (CE) begin
      wait_lock <= wait_lock + LOCK_CHK_W'(1);
    end
  end

  a_shutdown_tristate: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && shutdown |=> !CLK_OUT_A_OE && !CLK_OUT_B_OE && !CLK_OUT_C_OE && !OSC_ENABLE)
    else $error("outputs or oscillator active in shutdown");

  a_oe_low_tristate: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && out_disable |=> oe_q == '0)
    else $error("output driven while output enable low");

  a_oe_high_drives: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && MFI_MODE == MFI_OUT_ENABLE && fs_s2 |=> oe_q == '1)
    else $error("output not driven while output enable high");

  a_shutdown_stops_loops: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && shutdown ##1 CE && shutdown |-> loop_tick == '0 && LOOP_LOCKED == '0)
    else $error("loop running during shutdown");

  a_relock_gates_src: assert property (@(posedge CORE_CLK) disable iff (RST)
    !LOOP_LOCKED[0] |-> !src_tick[1])
    else $error("unlocked loop reached crosspoint");

  a_lock_within_max: assert property (@(posedge CORE_CLK) disable iff (RST)
    wait_lock <= LOCK_CHK_MAX)
    else $error("loop one lock took longer than maximum");

  a_suspend_out_off: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && suspend && !shutdown |=> (oe_q & $past(SUSPEND_OUTS)) == '0)
    else $error("suspended output still driven");

  a_suspend_loop_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && suspend && SUSPEND_LOOPS[1] ##1 CE && suspend && SUSPEND_LOOPS[1] |-> !loop_tick[1] && !LOOP_LOCKED[1])
    else $error("suspended loop two still running");

  a_bypass_no_feedback: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && CAP_BYPASS ##1 CAP_BYPASS |-> !OSC_FEEDBACK_OUT_OE && LOAD_CAP_SEL == CAP_OFF)
    else $error("load caps or feedback active in bypass");

  a_loop_tick_cause: assert property (@(posedge CORE_CLK) disable iff (RST)
    loop_tick[2] |-> loop_run[2] && g_loop[2].credit >= g_loop[2].pre_eff)
    else $error("loop three ticked without credit");

  a_shutdown_div_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && shutdown |=> div_q == '0)
    else $error("post divider running in shutdown");

  a_shutdown_ref_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
    shutdown |-> !ref_tick && !ref_rise)
    else $error("reference ticks during shutdown");

  a_unlocked_out_still: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && !shutdown && !LOOP_LOCKED[0] && SRC_SEL_A == SRC_LOOP_ONE |=> $stable(div_q[0]))
    else $error("output A moved before loop one locked");

  a_cap_follows_code: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && !CAP_BYPASS |=> LOAD_CAP_SEL == $past(LOAD_CAP_CODE))
    else $error("load capacitance code not applied");

  a_drive_follows_cfg: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE |=> OSC_DRIVE_SEL == $past(OSC_DRIVE))
    else $error("oscillator drive setting not applied");

  a_fs_loop_one_set: assert property (@(posedge CORE_CLK) disable iff (RST)
    fs_high |-> loop_pre[0] == LOOP_ONE_PRE_1 && loop_fb[0] == LOOP_ONE_FB_1)
    else $error("loop one ignores frequency select");

  a_fs_mode_only: assert property (@(posedge CORE_CLK) disable iff (RST)
    !fs_mode |-> loop_pre[0] == LOOP_ONE_PRE_0 && div_sel[0] == DIV_A_0 && div_sel[1] == DIV_B_0)
    else $error("frequency select acting outside its mode");

  a_div_ab_select: assert property (@(posedge CORE_CLK) disable iff (RST)
    fs_high |-> div_sel[0] == DIV_A_1 && div_sel[1] == DIV_B_1)
    else $error("outputs A or B ignore frequency select");

  a_div_c_fixed: assert property (@(posedge CORE_CLK) disable iff (RST)
    div_sel[2] == DIV_C)
    else $error("output C divider follows frequency select");

  a_route_c: assert property (@(posedge CORE_CLK) disable iff (RST)
    out_tick[2] == src_tick[SRC_SEL_C])
    else $error("output C routed from wrong source");

  a_invert_phase: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE |=> clk_q == ($past(div_q) ^ $past(INVERT_PHASE)))
    else $error("output phase not as configured");

  a_fs_with_suspend: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && fs_mode && SUSPEND_WITH_FS && pin_low |=> (oe_q & $past(SUSPEND_OUTS)) == '0)
    else $error("suspend not applied with frequency select");

  a_suspend_high_drives: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE && MFI_MODE == MFI_SUSPEND && fs_s2 |=> oe_q == '1)
    else $error("output off while suspend pin high");

  // loops two and three get the same lock deadline as loop one
  for (genvar k = 1; k < NUM_LOOPS; k++) begin : g_lock_chk
    logic [LOCK_CHK_W-1:0] waited;

    always_ff @(posedge CORE_CLK) begin
      if (RST || !loop_run[k] || LOOP_LOCKED[k]) begin
        waited <= '0;
      end else if (CE) begin
        waited <= waited + LOCK_CHK_W'(1);
      end
    end

    a_lock_max_each: assert property (@(posedge CORE_CLK) disable iff (RST)
      waited <= LOCK_CHK_MAX)
      else $error("loop lock took longer than maximum");
  end
endmodule : tlrc_clock_ctrl

// file: tb/tlrc_ref_model.sv
// reference clock source standing where the crystal sits
// assumes the core clock; it swings only while the device keeps its oscillator enabled
module tlrc_ref_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic run,
  output logic ref_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial ref_out = 1'b0;
  // a stopped oscillator rests low; the feedback pin is left floating
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      ref_out <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ref_out <= ~ref_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : tlrc_ref_model

// file: tb/testbench.sv
// self-checking bench of the clock router: periods, enables and static selections
// assumes loop ratios chosen so each output period spans whole reference periods
module testbench;
  import tlrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOCK = 20;
  localparam int HALF = 8;
  typedef struct {string what; int kind; logic [31:0] exp;} tlrc_note_s;
  tlrc_note_s notes[$];
  int errors = 0;
  int num_checks = 0;
  logic clk = 1'b0, rst = 1'b1, fs = 1'b0, swf = 1'b0, byp = 1'b0, ce = 1'b1;
  tlrc_mfi_e mode = MFI_FREQ_SEL;
  tlrc_src_e sa = SRC_REF, sb = SRC_LOOP_ONE, sc = SRC_REF;
  logic [PRE_W-1:0] p10 = 8'h01, p11 = 8'h01, p2 = 8'hc8, p3 = 8'h03;
  logic [FB_W-1:0] f10 = 11'h002, f11 = 11'h004, f2 = 11'h4b0, f3 = 11'h004;
  logic [PD_W-1:0] da0 = 7'h02, da1 = 7'h05, db0 = 7'h02, db1 = 7'h08, dc = 7'h01;
  logic [2:0] inv = 3'h0, sl = 3'h0, so = 3'h0, oe, lk;
  logic [5:0] clks;
  logic [CAP_W-1:0] cap = 6'h00, cap_sel;
  logic [DRV_W-1:0] drv = 2'h0, drv_sel;
  logic ca, cb, cc, oa, ob, oc, ena, fbo, fb_oe, ref_clk;
  assign clks = {fbo, 2'b00, cc, cb, ca};
  assign oe = {oc, ob, oa};
  always #5 clk = ~clk;
  tlrc_ref_model #(.HALF(HALF)) tlrc_ref_model_i (.clk(clk), .run(ena), .ref_out(ref_clk));
  tlrc_clock_ctrl #(.LOCK_CYCLES(LOCK)) tlrc_clock_ctrl_i (
    .CORE_CLK(clk), .RST(rst), .CE(ce), .REF_IN(ref_clk), .FREQ_SELECT(fs), .MFI_MODE(mode),
    .SUSPEND_WITH_FS(swf), .LOOP_ONE_PRE_0(p10), .LOOP_ONE_FB_0(f10), .LOOP_ONE_PRE_1(p11),
    .LOOP_ONE_FB_1(f11), .LOOP_TWO_PRE(p2), .LOOP_TWO_FB(f2), .LOOP_THREE_PRE(p3), .LOOP_THREE_FB(f3),
    .SRC_SEL_A(sa), .SRC_SEL_B(sb), .SRC_SEL_C(sc), .DIV_A_0(da0), .DIV_A_1(da1), .DIV_B_0(db0),
    .DIV_B_1(db1), .DIV_C(dc), .INVERT_PHASE(inv), .SUSPEND_LOOPS(sl), .SUSPEND_OUTS(so),
    .LOAD_CAP_CODE(cap), .OSC_DRIVE(drv), .CAP_BYPASS(byp), .CLK_OUT_A(ca), .CLK_OUT_A_OE(oa),
    .CLK_OUT_B(cb), .CLK_OUT_B_OE(ob), .CLK_OUT_C(cc), .CLK_OUT_C_OE(oc), .OSC_FEEDBACK_OUT(fbo),
    .OSC_FEEDBACK_OUT_OE(fb_oe), .OSC_ENABLE(ena), .LOAD_CAP_SEL(cap_sel), .OSC_DRIVE_SEL(drv_sel),
    .LOOP_LOCKED(lk));
  ////////////////////////////////////////
  function automatic logic [31:0] per_of(input int s, input int d);
    int q;
    int p;
    q = s == 2 ? p2 : s == 3 ? p3 : fs ? p11 : p10;
    p = s == 2 ? f2 : s == 3 ? f3 : fs ? f11 : f10;
    return s == 0 ? 32'(2 * HALF * d) : 32'(2 * HALF * d * q / p);
  endfunction : per_of
  task automatic note(input string what, input int kind, input logic [31:0] exp);
    notes.push_back('{what, kind, exp});
    wait (notes.size() == 0);
    @(negedge clk);
  endtask : note
  task automatic stat(input logic [2:0] o, input logic [2:0] l, input logic e);
    note("status", 4, {16'h0, o, l, e, e & !byp, byp ? 6'h00 : cap, drv});
  endtask : stat
  task automatic settle();
    repeat (LOCK + 10) @(negedge clk);
  endtask : settle
  // kinds 0..2 period of an output, 3 coincident A/B rises, 4 status word, 5 feedback period
  task automatic measure(input int kind, output logic [31:0] v);
    int t0;
    int c;
    logic [5:0] prev;
    logic [5:0] rise;
    v = 32'h0;
    c = 0;
    t0 = 0;
    prev = clks;
    if (kind == 4) begin
      v = {16'h0, oe, lk, ena, fb_oe, cap_sel, drv_sel};
    end else begin
      // the first two periods may straddle a divider change, so skip them
      for (int t = 1; t < 5000 && c < 4; t++) begin
        @(posedge clk);
        #1;
        rise = clks & ~prev;
        prev = clks;
        if (kind == 3) begin
          v = v + 32'(rise[0] & rise[1]);
          if (t == 192) c = 4;
        end else if (rise[kind]) begin
          c++;
          if (c == 3) t0 = t;
          if (c == 4) v = 32'(t - t0);
        end
      end
    end
  endtask : measure
  initial begin : watcher
    tlrc_note_s n;
    logic [31:0] v;
    forever begin
      wait (notes.size() > 0);
      n = notes[0];
      measure(n.kind, v);
      num_checks++;
      if (v !== n.exp) begin
        errors++;
        $display("CHECK FAILED %s expected %0h seen %0h", n.what, n.exp, v);
      end
      void'(notes.pop_front());
    end
  end
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin : watchdog
    #200000;
    errors++;
    print_verdict();
  end
  initial begin : main
    int r;
    r = $urandom(51773);
    @(negedge clk);
    cap = 6'($urandom());
    drv = 2'($urandom());
    @(negedge clk);
    rst = 1'b0;
    settle();
    stat(3'h7, 3'h7, 1'b1);
    note("osc_feedback", 5, per_of(0, 1));
    dc = 7'h0c;
    for (int s = 0; s < 4; s++) begin
      sc = tlrc_src_e'(s);
      settle();
      note("period_c", 2, per_of(s, 12));
    end
    sc = SRC_REF;
    dc = 7'h01;
    settle();
    note("period_c", 2, per_of(0, 1));
    sc = SRC_LOOP_TWO;
    dc = 7'h06;
    for (int s = 0; s < 3; s++) begin
      fs = s[0];
      settle();
      note("period_a", 0, per_of(0, fs ? da1 : da0));
      note("period_b", 1, per_of(1, fs ? db1 : db0));
      note("period_c", 2, per_of(2, dc));
    end
    sa = SRC_LOOP_ONE;
    mode = MFI_OUT_ENABLE;
    settle();
    stat(3'h0, 3'h7, 1'b1);
    fs = 1'b1;
    settle();
    stat(3'h7, 3'h7, 1'b1);
    // clock enable low: the shutdown request may not act yet
    ce = 1'b0;
    mode = MFI_SHUTDOWN;
    fs = 1'b0;
    settle();
    stat(3'h7, 3'h7, 1'b1);
    ce = 1'b1;
    settle();
    stat(3'h0, 3'h0, 1'b0);
    fs = 1'b1;
    repeat (5) @(negedge clk);
    stat(3'h7, 3'h0, 1'b1);
    settle();
    stat(3'h7, 3'h7, 1'b1);
    // dividers A and B restart together after shutdown, so A never rises together with inverted B
    inv = 3'h2;
    settle();
    note("coincident_rises", 3, 32'h0);
    inv = 3'h0;
    mode = MFI_SUSPEND;
    sb = SRC_LOOP_TWO;
    sl = 3'h2;
    so = 3'h2;
    fs = 1'b0;
    settle();
    stat(3'h5, 3'h5, 1'b1);
    fs = 1'b1;
    settle();
    stat(3'h7, 3'h7, 1'b1);
    mode = MFI_FREQ_SEL;
    swf = 1'b1;
    fs = 1'b0;
    settle();
    stat(3'h5, 3'h5, 1'b1);
    note("period_a", 0, per_of(1, da0));
    fs = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cap = 6'($urandom());
      drv = 2'($urandom());
      byp = i[0];
      settle();
      stat(3'h7, 3'h7, 1'b1);
    end
    print_verdict();
  end
endmodule : testbench
